// [core/wait_oneshot_timer.sv]
// Delayed one-shot pulse timer with register port and trigger pin.
// Assumes a one-cycle strobe register master on mclk; trigger pin asynchronous.
//
// Function
// [RL1] Count from one of four selectable sources
// [RL2] Primary wait, then secondary loaded for pulse
// [RL3] Secondary underflow reloads primary, then stops
// [RL4] Any stop reloads counter from reload values
// [RL5] Wait lasts (n+1)(m+1) source periods
// [RL6] Pulse lasts (n+1)(l+1) source periods
// [RL7] Start bit starts run; run flag set
// [RL8] Trigger edge starts run when all enabled
// [RL9] Normal run ends after secondary zero reload
// [RL10] Clearing run flag or start stops
// [RL11] Interrupt at secondary zero, not wait end
// [RL12] Software stop sets interrupt request flag
// [RL13] Software masks interrupts and clears flag (no mask bit; an IRQ write with bit 0 low clears the flag)
// [RL14] Primary and prescaler reads return live counts
// [RL15] Writes change reload values, not counter
// [RL16] Values commit on primary write, next pulse
// [RL17] Software selects pulse active level
// [RL18] Trigger enable and edge select rising/falling/both
// [RL19] Extension bits add half source cycle
// [RL20] Prescaler zero whenever extension used
// [RL21] No extension with undivided or companion source
// [RL22] Mode field 11 selects this mode
// [RL23] Level select 0 high pulse, 1 low
// [RL24] Run flag 0 stops, 1 allows
// [RL25] Triggers ignored while a run is active
// [RL26] Output idle except during pulse phase
//
// Local design decisions: the plain strobed port and the register offsets.
module wait_oneshot_timer (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ext_trigger_pin,
  input wire logic companion_underflow,
  input wire logic subclk_pin,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  output logic pulse_out_pin,
  output logic irq_req
);

  localparam int EXT_MAX = 8;

  logic [7:0] ctrl_ff;
  logic [7:0] wave_ff;
  logic [7:0] pre_buf_ff;
  logic [7:0] sec_buf_ff;
  logic [7:0] pri_buf_ff;
  logic [7:0] pre_act_ff;
  logic [7:0] sec_act_ff;
  logic [7:0] pri_act_ff;
  logic pend_ff;
  logic [7:0] pre_ff;
  logic [7:0] cnt_ff;
  logic irq_ff;
  logic [7:0] rdata_ff;
  logic out_ff;
  logic trig1_ff;
  logic trig2_ff;
  logic trig3_ff;
  otimer_pkg::state_t state_ff;
  otimer_pkg::state_t nxt_state;
  logic wr_ctrl;
  logic wr_wave;
  logic wr_pre;
  logic wr_pri;
  logic wr_sec;
  logic wr_irq;
  logic mode_ok;
  logic running;
  logic sw_start;
  logic sw_stop;
  logic trig_edge;
  logic hw_trig;
  logic start;
  logic uflow;
  logic normal_end;
  logic irq_set;
  logic alt_ff;
  logic cnt_tick;
  logic ext_half;

  cs_if cs ();

  count_source u_src (
    .mclk(mclk),
    .resetn(resetn),
    .companion_underflow(companion_underflow),
    .subclk_pin(subclk_pin),
    .cs(cs.src)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic is_pulse(input otimer_pkg::state_t s);
    is_pulse = (s == otimer_pkg::S_PULSE) || (s == otimer_pkg::S_PULSE_EXT);
  endfunction : is_pulse

  assign wr_ctrl = wr_stb && hit(addr, otimer_pkg::OFS_CTRL);
  assign wr_wave = wr_stb && hit(addr, otimer_pkg::OFS_WAVE);
  assign wr_pre = wr_stb && hit(addr, otimer_pkg::OFS_PRE);
  assign wr_pri = wr_stb && hit(addr, otimer_pkg::OFS_PRI);
  assign wr_sec = wr_stb && hit(addr, otimer_pkg::OFS_SEC);
  assign wr_irq = wr_stb && hit(addr, otimer_pkg::OFS_IRQ);
  assign cs.sel = ctrl_ff[otimer_pkg::CB_SRC_HI:otimer_pkg::CB_SRC_LO]; // [RL1]

  // ----------------------------------------------------------------
  // Start and stop conditions
  // ----------------------------------------------------------------
  assign mode_ok = (ctrl_ff[otimer_pkg::CB_MODE1:otimer_pkg::CB_MODE0]
                    == otimer_pkg::MODE_WAIT_ONESHOT); // [RL22]
  assign running = (state_ff != otimer_pkg::S_IDLE);
  assign sw_start = wr_ctrl && wdata[otimer_pkg::CB_START] && wdata[otimer_pkg::CB_RUN]
                    && ctrl_ff[otimer_pkg::CB_RUN] && mode_ok; // [RL7]

  always_comb
  begin
    case (wave_ff[otimer_pkg::WB_EDGE_HI:otimer_pkg::WB_EDGE_LO])
      otimer_pkg::EDGE_RISE: trig_edge = trig2_ff & ~trig3_ff; // [RL18]
      otimer_pkg::EDGE_FALL: trig_edge = ~trig2_ff & trig3_ff;
      default: trig_edge = trig2_ff ^ trig3_ff;
    endcase
  end

  assign hw_trig = trig_edge && ctrl_ff[otimer_pkg::CB_RUN] && wave_ff[otimer_pkg::WB_TIE]
                   && wave_ff[otimer_pkg::WB_TVB] && mode_ok; // [RL8] [RL18]
  assign start = !running && (sw_start || hw_trig); // [RL25]
  assign sw_stop = running && wr_ctrl && (!wdata[otimer_pkg::CB_RUN]
                   || !wdata[otimer_pkg::CB_START] || (wdata[otimer_pkg::CB_MODE1:
                   otimer_pkg::CB_MODE0] != otimer_pkg::MODE_WAIT_ONESHOT)); // [RL10] [RL24]
  assign cnt_tick = alt_ff ? cs.half : cs.tick; // [RL19]
  assign ext_half = alt_ff ? cs.tick : cs.half; // [RL19]
  assign uflow = cnt_tick && (pre_ff == 8'h00) && (cnt_ff == 8'h00) && ((state_ff ==
                 otimer_pkg::S_WAIT) || (state_ff == otimer_pkg::S_PULSE)); // [RL5] [RL6]
  assign normal_end = running && (nxt_state == otimer_pkg::S_IDLE) && !sw_stop;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      otimer_pkg::S_IDLE:
        if (start)
          nxt_state = otimer_pkg::S_WAIT; // [RL7] [RL8]
      otimer_pkg::S_WAIT:
        if (sw_stop)
          nxt_state = otimer_pkg::S_IDLE; // [RL10]
        else if (uflow)
          nxt_state = wave_ff[otimer_pkg::WB_WEXT] ? otimer_pkg::S_WAIT_EXT
                      : otimer_pkg::S_PULSE; // [RL2] [RL19]
      otimer_pkg::S_WAIT_EXT:
        if (sw_stop)
          nxt_state = otimer_pkg::S_IDLE;
        else if (cs.half)
          nxt_state = otimer_pkg::S_PULSE; // [RL19]
      otimer_pkg::S_PULSE:
        if (sw_stop)
          nxt_state = otimer_pkg::S_IDLE;
        else if (uflow)
          nxt_state = wave_ff[otimer_pkg::WB_PEXT] ? otimer_pkg::S_PULSE_EXT
                      : otimer_pkg::S_IDLE; // [RL3] [RL9] [RL19]
      otimer_pkg::S_PULSE_EXT:
        if (sw_stop || ext_half)
          nxt_state = otimer_pkg::S_IDLE; // [RL19]
      default:
        nxt_state = otimer_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      state_ff <= otimer_pkg::S_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Pulse counts on half ticks after an extended wait, so it keeps full length
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      alt_ff <= 1'b0;
    else if (nxt_state == otimer_pkg::S_IDLE)
      alt_ff <= 1'b0;
    else if (state_ff == otimer_pkg::S_WAIT_EXT)
      alt_ff <= 1'b1; // [RL19]
  end

  // ----------------------------------------------------------------
  // Prescaler and counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pre_ff <= otimer_pkg::CNT_RST;
      cnt_ff <= otimer_pkg::CNT_RST;
    end
    else if (nxt_state == otimer_pkg::S_IDLE)
    begin
      pre_ff <= pre_act_ff; // [RL4]
      cnt_ff <= pri_act_ff; // [RL4] [RL9]
    end
    else if (uflow)
    begin
      pre_ff <= pre_act_ff;
      cnt_ff <= (state_ff == otimer_pkg::S_WAIT) ? sec_act_ff : pri_act_ff; // [RL2] [RL3]
    end
    else if (cnt_tick && ((state_ff == otimer_pkg::S_WAIT) || (state_ff == otimer_pkg::S_PULSE)))
    begin
      if (pre_ff == 8'h00)
      begin
        pre_ff <= pre_act_ff; // [RL5] [RL6]
        cnt_ff <= cnt_ff - 8'h01;
      end
      else
      begin
        pre_ff <= pre_ff - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_ff <= otimer_pkg::CTRL_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_ff <= wdata;
      if (start && hw_trig)
        ctrl_ff[otimer_pkg::CB_START] <= 1'b1;
      if (normal_end)
        ctrl_ff[otimer_pkg::CB_START] <= 1'b0; // [RL9]
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      wave_ff <= otimer_pkg::WAVE_RST;
    else if (wr_wave)
      wave_ff <= wdata; // [RL17] [RL18] [RL19]
  end

  // ----------------------------------------------------------------
  // Reload buffers and commit
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pre_buf_ff <= otimer_pkg::CNT_RST;
      sec_buf_ff <= otimer_pkg::CNT_RST;
      pri_buf_ff <= otimer_pkg::CNT_RST;
    end
    else
    begin
      if (wr_pre)
        pre_buf_ff <= wdata; // [RL15]
      if (wr_sec)
        sec_buf_ff <= wdata;
      if (wr_pri)
        pri_buf_ff <= wdata; // [RL15]
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pre_act_ff <= otimer_pkg::CNT_RST;
      sec_act_ff <= otimer_pkg::CNT_RST;
      pri_act_ff <= otimer_pkg::CNT_RST;
      pend_ff <= 1'b0;
    end
    else if (!running && (pend_ff || wr_pri))
    begin
      pre_act_ff <= pre_buf_ff; // [RL16]
      sec_act_ff <= sec_buf_ff;
      pri_act_ff <= wr_pri ? wdata : pri_buf_ff;
      pend_ff <= 1'b0;
    end
    else if (wr_pri)
    begin
      pend_ff <= 1'b1; // [RL16]
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request flag
  // ----------------------------------------------------------------
  assign irq_set = ((state_ff == otimer_pkg::S_PULSE) && uflow) || sw_stop; // [RL11] [RL12]

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      irq_ff <= 1'b0;
    else if (irq_set)
      irq_ff <= 1'b1; // [RL11] [RL12]
    else if (wr_irq && !wdata[otimer_pkg::IB_FLAG])
      irq_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rdata_ff <= 8'h00;
    else if (!rd_stb)
      rdata_ff <= 8'h00;
    else
      case (addr)
        otimer_pkg::OFS_CTRL: rdata_ff <= ctrl_ff;
        otimer_pkg::OFS_WAVE: rdata_ff <= wave_ff;
        otimer_pkg::OFS_PRE: rdata_ff <= pre_ff; // [RL14]
        otimer_pkg::OFS_PRI: rdata_ff <= cnt_ff; // [RL14]
        otimer_pkg::OFS_SEC: rdata_ff <= sec_buf_ff;
        otimer_pkg::OFS_IRQ: rdata_ff <= {7'h00, irq_ff};
        default: rdata_ff <= 8'h00;
      endcase
  end

  // ----------------------------------------------------------------
  // Trigger synchroniser and pulse output
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      trig1_ff <= 1'b0;
      trig2_ff <= 1'b0;
      trig3_ff <= 1'b0;
    end
    else
    begin
      trig1_ff <= ext_trigger_pin;
      trig2_ff <= trig1_ff;
      trig3_ff <= trig2_ff;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      out_ff <= 1'b0;
    else
      out_ff <= is_pulse(nxt_state) ^ wave_ff[otimer_pkg::WB_OLS]; // [RL23] [RL26]
  end

  assign rdata = rdata_ff;
  assign pulse_out_pin = out_ff;
  assign irq_req = irq_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_out_level: assert property ( // [RL23] [RL26]
    @(posedge mclk) disable iff (!resetn)
    pulse_out_pin == (is_pulse(state_ff) ^ $past(wave_ff[otimer_pkg::WB_OLS])))
    else $error("pulse output level wrong for phase");

  a_sw_start: assert property ( // [RL7]
    @(posedge mclk) disable iff (!resetn)
    (!running && sw_start) |=> (state_ff == otimer_pkg::S_WAIT) && ctrl_ff[otimer_pkg::CB_START])
    else $error("software start did not begin wait");

  a_trig_gate: assert property ( // [RL8]
    @(posedge mclk) disable iff (!resetn)
    (!running && !sw_start && trig_edge && !(ctrl_ff[otimer_pkg::CB_RUN]
     && wave_ff[otimer_pkg::WB_TIE] && wave_ff[otimer_pkg::WB_TVB]))
    |=> (state_ff == otimer_pkg::S_IDLE))
    else $error("disabled trigger started a run");

  a_sw_stop: assert property ( // [RL10] [RL12]
    @(posedge mclk) disable iff (!resetn)
    (running && wr_ctrl && !wdata[otimer_pkg::CB_RUN])
    |=> (state_ff == otimer_pkg::S_IDLE) && irq_req)
    else $error("software stop not honoured");

  a_pulse_end: assert property ( // [RL3] [RL11]
    @(posedge mclk) disable iff (!resetn)
    (state_ff == otimer_pkg::S_PULSE && uflow && !wave_ff[otimer_pkg::WB_PEXT])
    |=> (state_ff == otimer_pkg::S_IDLE) && irq_req && (cnt_ff == $past(pri_act_ff)))
    else $error("pulse end did not reload and request");

  a_wait_no_irq: assert property ( // [RL11]
    @(posedge mclk) disable iff (!resetn)
    (state_ff == otimer_pkg::S_WAIT && uflow && !wr_stb && !irq_req)
    |=> !irq_req && (cnt_ff == $past(sec_act_ff)))
    else $error("wait end raised request or missed secondary");

  a_wr_reload_only: assert property ( // [RL15]
    @(posedge mclk) disable iff (!resetn)
    (running && (wr_pri || wr_pre) && !cnt_tick && !sw_stop) |=> $stable(cnt_ff) && $stable(pre_ff))
    else $error("write disturbed the running counter");

  a_read_live: assert property ( // [RL14]
    @(posedge mclk) disable iff (!resetn)
    (rd_stb && addr == otimer_pkg::OFS_PRI) |=> (rdata == $past(cnt_ff)))
    else $error("primary read not the live count");

  a_no_retrig: assert property ( // [RL25]
    @(posedge mclk) disable iff (!resetn)
    (state_ff == otimer_pkg::S_PULSE && !uflow && !sw_stop && (hw_trig || sw_start))
    |=> (state_ff == otimer_pkg::S_PULSE))
    else $error("trigger accepted during a run");

  a_stop_reload: assert property ( // [RL4] [RL9]
    @(posedge mclk) disable iff (!resetn)
    ($past(running) && !running) |-> (cnt_ff == $past(pri_act_ff)) && (pre_ff == $past(pre_act_ff)))
    else $error("stop did not reload counter");

  a_ext_half: assert property ( // [RL19]
    @(posedge mclk) disable iff (!resetn)
    (state_ff == otimer_pkg::S_WAIT_EXT && cs.sel == otimer_pkg::SRC_F8)
    |-> ##[1:EXT_MAX] (state_ff != otimer_pkg::S_WAIT_EXT))
    else $error("wait extension overran half cycle");

endmodule : wait_oneshot_timer

// [shared/otimer_pkg.sv]
// Constants, register map and state type for the wait one-shot timer.
// Assumes an 8-bit register port and a single clock domain.
package otimer_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_WAVE = 5'h04;
  localparam logic [4:0] OFS_PRE = 5'h08;
  localparam logic [4:0] OFS_PRI = 5'h0C;
  localparam logic [4:0] OFS_SEC = 5'h10;
  localparam logic [4:0] OFS_IRQ = 5'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CB_MODE0 = 0;
  localparam int CB_MODE1 = 1;
  localparam int CB_RUN = 2;
  localparam int CB_START = 3;
  localparam int CB_SRC_LO = 4;
  localparam int CB_SRC_HI = 5;
  localparam int WB_WEXT = 0;
  localparam int WB_PEXT = 1;
  localparam int WB_OLS = 2;
  localparam int WB_TVB = 3;
  localparam int WB_TIE = 4;
  localparam int WB_EDGE_LO = 5;
  localparam int WB_EDGE_HI = 6;
  localparam int IB_FLAG = 0;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_WAIT_ONESHOT = 2'h3;
  localparam logic [1:0] SRC_F1 = 2'h0;
  localparam logic [1:0] SRC_F8 = 2'h1;
  localparam logic [1:0] SRC_COMP = 2'h2;
  localparam logic [1:0] SRC_SUB = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [2:0] F8_TICK = 3'h7;
  localparam logic [2:0] F8_HALF = 3'h3;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] WAVE_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;

  typedef enum logic [2:0] {S_IDLE, S_WAIT, S_WAIT_EXT, S_PULSE, S_PULSE_EXT} state_t;

endpackage : otimer_pkg

// [shared/cs_if.sv]
// Count source link between the timer core and its tick generator.
// Assumes both ends run on mclk.
interface cs_if;
  logic [1:0] sel;
  logic tick;
  logic half;
  modport src (input sel, output tick, output half);
  modport sink (output sel, input tick, input half);
endinterface : cs_if

// [core/count_source.sv]
// Count source tick generator: undivided, divide-by-8, companion, subclock.
// Assumes companion_underflow is an mclk pulse and subclk_pin is asynchronous.
module count_source (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic companion_underflow,
  input wire logic subclk_pin,
  cs_if.src cs
);

  logic [2:0] div_ff;
  logic sub1_ff;
  logic sub2_ff;
  logic sub3_ff;

  // ----------------------------------------------------------------
  // Divider and subclock synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_ff <= 3'h0;
    end
    else
    begin
      div_ff <= div_ff + 3'h1;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sub1_ff <= 1'b0;
      sub2_ff <= 1'b0;
      sub3_ff <= 1'b0;
    end
    else
    begin
      sub1_ff <= subclk_pin;
      sub2_ff <= sub1_ff;
      sub3_ff <= sub2_ff;
    end
  end

  // ----------------------------------------------------------------
  // Tick select
  // ----------------------------------------------------------------
  always_comb
  begin
    case (cs.sel)
      otimer_pkg::SRC_F1:
      begin
        cs.tick = 1'b1; // [RL1]
        cs.half = 1'b1;
      end
      otimer_pkg::SRC_F8:
      begin
        cs.tick = (div_ff == otimer_pkg::F8_TICK); // [RL1]
        cs.half = (div_ff == otimer_pkg::F8_HALF);
      end
      otimer_pkg::SRC_COMP:
      begin
        cs.tick = companion_underflow; // [RL1]
        cs.half = companion_underflow;
      end
      otimer_pkg::SRC_SUB:
      begin
        cs.tick = sub2_ff & ~sub3_ff; // [RL1]
        cs.half = ~sub2_ff & sub3_ff;
      end
      default:
      begin
        cs.tick = 1'b0;
        cs.half = 1'b0;
      end
    endcase
  end

endmodule : count_source

// [dv/trig_source.sv]
// External trigger source model for the timer's trigger pin.
// Assumes it shares mclk with the bench; the pin is a plain level.
module trig_source (
  input wire logic mclk,
  output logic ext_trigger_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial ext_trigger_pin = 1'b0;

  // ----------------------------------------------------------------
  // Level drive
  // ----------------------------------------------------------------
  // One level change right after an edge, held until the next call
  task automatic set_level(input logic lvl);
    @(posedge mclk);
    ext_trigger_pin <= lvl;
  endtask : set_level
endmodule : trig_source

// [dv/tb_top.sv]
// Self-checking bench for the wait one-shot timer: random and corner runs.
// Assumes the package, design files and trigger model compile first.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) check_val(g, e)

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic companion_underflow = 1'b0;
  logic subclk_pin = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] rdata;
  logic pulse_out_pin;
  logic irq_req;
  logic ext_trigger_pin;
  logic [7:0] rv;
  int err_total = 0;
  int num_checks = 0;
  int cc = 0;
  int k;
  integer seed = 32'h499d;
  logic [7:0] wv [4] = '{8'h08, 8'h10, 8'h18, 8'h00};
  logic [7:0] cv [4] = '{8'h07, 8'h07, 8'h03, 8'h04};

  wait_oneshot_timer wait_oneshot_timer_inst (
    .mclk(mclk), .resetn(resetn), .ext_trigger_pin(ext_trigger_pin),
    .companion_underflow(companion_underflow), .subclk_pin(subclk_pin),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .pulse_out_pin(pulse_out_pin), .irq_req(irq_req)
  );

  trig_source trig_source_inst (
    .mclk(mclk),
    .ext_trigger_pin(ext_trigger_pin)
  );

  // ----------------------------------------------------------------
  // Clock and count sources: companion every 3, subclock every 10
  // ----------------------------------------------------------------
  always #2 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cc <= (cc == 29) ? 0 : cc + 1;
    companion_underflow <= (cc % 3 == 0);
    subclk_pin <= (cc % 10 >= 5);
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic int per(input int s);
    return (s == 0) ? 1 : (s == 1) ? 8 : (s == 2) ? 3 : 10;
  endfunction : per

  function automatic int hlf(input int s);
    return (s == 1) ? 4 : (s == 3) ? 5 : 0;
  endfunction : hlf

  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check_val

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 rv = rdata;
  endtask : rd

  // One full run from software start or trigger edge, timed at the pin
  task automatic run_once(input int s, n, m, l, input logic ols, we, pe, hw, input int e);
    int w;
    logic [1:0] es;
    es = e[1:0];
    w = 0;
    wr(otimer_pkg::OFS_WAVE, 8'h00);
    trig_source_inst.set_level(e == 1);
    wr(otimer_pkg::OFS_PRE, n[7:0]);
    wr(otimer_pkg::OFS_SEC, l[7:0]);
    wr(otimer_pkg::OFS_WAVE, {1'b0, es, hw, hw, ols, pe, we});
    wr(otimer_pkg::OFS_PRI, m[7:0]);
    wr(otimer_pkg::OFS_IRQ, 8'h00);
    wr(otimer_pkg::OFS_CTRL, 8'h07 | (s[7:0] << 4));
    #1 `CHK(pulse_out_pin, ols);
    if (hw)
      trig_source_inst.set_level(e != 1);
    else
      wr(otimer_pkg::OFS_CTRL, 8'h0F | (s[7:0] << 4));
    k = 0;
    #1;
    while (pulse_out_pin !== ~ols && k < 4000)
    begin
      @(posedge mclk);
      #1 k++;
    end
    if (!hw && s == 0) `CHK(k, (n + 1) * (m + 1));
    `CHK(irq_req, 1'b0);
    while (pulse_out_pin === ~ols && w < 4000)
    begin
      @(posedge mclk);
      #1 w++;
    end
    `CHK(w, per(s) * (n + 1) * (l + 1) + hlf(s) * pe);
    `CHK(irq_req, 1'b1);
    rd(otimer_pkg::OFS_PRI);
    `CHK(rv, m[7:0]);
  endtask : run_once

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int s, n, m, l;
    logic we, pe;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    wr(5'h1C, 8'hFF);
    for (int a = 0; a < 8; a++)
    begin
      rd(5'(a * 4));
      `CHK(rv, 8'h00);
    end
    run_once(0, 0, 0, 0, 1'b0, 1'b0, 1'b0, 1'b0, 0);
    run_once(3, 0, 7, 7, 1'b1, 1'b1, 1'b1, 1'b1, 2);
    repeat (14)
    begin
      s = $unsigned($random(seed)) % 4;
      we = s[0] & 1'($random(seed));
      pe = s[0] & 1'($random(seed));
      n = (we | pe) ? 0 : $unsigned($random(seed)) % 4;
      m = $unsigned($random(seed)) % 8;
      l = $unsigned($random(seed)) % 8;
      run_once(s, n, m, l, 1'($random(seed)), we, pe, 1'($random(seed)),
        $unsigned($random(seed)) % 3);
    end
    // Software stop in mid-wait
    wr(otimer_pkg::OFS_WAVE, 8'h00);
    wr(otimer_pkg::OFS_PRE, 8'h00);
    wr(otimer_pkg::OFS_PRI, 8'h30);
    wr(otimer_pkg::OFS_IRQ, 8'h00);
    wr(otimer_pkg::OFS_CTRL, 8'h17);
    wr(otimer_pkg::OFS_CTRL, 8'h1F);
    repeat (20) @(posedge mclk);
    rd(otimer_pkg::OFS_PRI);
    `CHK(rv < 8'h30 && rv > 8'h00, 1'b1);
    wr(otimer_pkg::OFS_PRE, 8'h05);
    rd(otimer_pkg::OFS_PRE);
    `CHK(rv, 8'h00);
    wr(otimer_pkg::OFS_CTRL, 8'h13);
    repeat (2) @(posedge mclk);
    #1 `CHK(irq_req, 1'b1);
    rd(otimer_pkg::OFS_PRI);
    `CHK(rv, 8'h30);
    // Gated starts: trigger enable off, valid off, run off, wrong mode
    for (int i = 0; i < 4; i++)
    begin
      wr(otimer_pkg::OFS_WAVE, 8'h00);
      trig_source_inst.set_level(1'b0);
      wr(otimer_pkg::OFS_PRI, 8'h02);
      wr(otimer_pkg::OFS_IRQ, 8'h00);
      wr(otimer_pkg::OFS_WAVE, wv[i]);
      wr(otimer_pkg::OFS_CTRL, cv[i]);
      if (i == 3)
        wr(otimer_pkg::OFS_CTRL, 8'h0C);
      else
        trig_source_inst.set_level(1'b1);
      k = 0;
      repeat (100)
      begin
        @(posedge mclk);
        #1 if (pulse_out_pin !== 1'b0 || irq_req !== 1'b0) k++;
      end
      `CHK(k, 0);
    end
    stop_test();
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (90000) @(posedge mclk);
    err_total++;
    stop_test();
  end
endmodule : tb_top
